// ==== dv/qsp_ctl_model.sv ====
`timescale 1ns/100ps
module qsp_ctl_model
  import qsp_pkg::*;
(
  input wire logic clk_sys,
  output qsp_cmd_t cmd
);
  initial cmd = '0;
  // one command word, held from just after an edge until the taking edge
  task automatic send(input logic wr, input logic g, input logic [2:0] s,
                      input logic [15:0] v, input logic pc, input logic cl);
    @(posedge clk_sys);
    #1 cmd = '{1'b1, wr, g, s, v, pc, cl};
    @(posedge clk_sys);
    #1 cmd = '{1'b0, wr, g, s, ~v, 1'b0, 1'b0}; // stale data scrambled
  endtask
endmodule

// ==== dv/qsp_status_properties.sv ====
`timescale 1ns/100ps
module qsp_chk
  import qsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire qsp_cmd_t cmd,
  input wire qsp_stat_t stat_pin,
  input wire logic front_panel_guard_reset,
  input wire logic legacy_mode,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic ques_summary,
  input wire logic rf_output_enable,
  input wire logic [15:0] output_power_condition
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // status pins pass a sync of 4-5 edges, so 8 held samples leave margin
  spare_zero_a: assert property (output_power_condition[15:2] == '0)
    else $error("spare bits set");
  rf_guard_a: assert property (
    rf_output_enable == !output_power_condition[0]) else $error("rf on");
  trip_kills_rf_a: assert property (stat_pin.guard_trip [*8] |->
    !rf_output_enable) else $error("trip missed");
  unlevel_flag_a: assert property (stat_pin.unleveled [*8] |->
    output_power_condition[1]) else $error("unlevel missed");
  query_answer_a: assert property (cmd.valid && !cmd.write |=> rd_valid)
    else $error("no answer");
  no_spur_a: assert property (rd_valid |->
    $past(cmd.valid) && !$past(cmd.write)) else $error("spurious answer");
  guard_clear_a: assert property ((!stat_pin.guard_trip) [*8] ##0
    (cmd.valid && cmd.prot_clear) |-> ##[1:2] rf_output_enable)
    else $error("clear ignored");
  legacy_clear_a: assert property ((!stat_pin.guard_trip) [*8] ##0
    (cmd.valid && legacy_mode) |-> ##[1:2] rf_output_enable)
    else $error("legacy clear ignored");
endmodule

bind qsp_status qsp_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .stat_pin(stat_pin),
  .front_panel_guard_reset(front_panel_guard_reset),
  .legacy_mode(legacy_mode), .rd_data(rd_data), .rd_valid(rd_valid),
  .ques_summary(ques_summary), .rf_output_enable(rf_output_enable),
  .output_power_condition(output_power_condition));

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import qsp_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic fp;
  logic lg;
  logic rf;
  logic rd_valid;
  logic ques_summary;
  logic [15:0] rd_data;
  logic [15:0] pcond;
  qsp_cmd_t cmd;
  qsp_stat_t st;
  int mismatches;
  int n_tests;

  qsp_ctl_model u_ctl (.clk_sys(clk_sys), .cmd(cmd));
  qsp_status u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd),
    .stat_pin(st), .front_panel_guard_reset(fp), .legacy_mode(lg),
    .rd_data(rd_data), .rd_valid(rd_valid), .ques_summary(ques_summary),
    .rf_output_enable(rf), .output_power_condition(pcond));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // answer stands one cycle only, so it is looked at right away
  task automatic q(input logic g, input logic [2:0] s, input logic [15:0] e,
                   input string nm);
    u_ctl.send(1'b0, g, s, 16'h0, 1'b0, 1'b0);
    chk(nm, e, (rd_valid === 1'b1) ? rd_data : 16'hdead);
  endtask

  task automatic w(input logic g, input logic [2:0] s, input logic [15:0] v);
    u_ctl.send(1'b1, g, s, v, 1'b0, 1'b0);
  endtask

  task automatic t_regs;
    q(0, 3'h2, 16'hffff, "rise_rst");
    q(1, 3'h3, 16'h0, "fall_rst");
    w(0, 3'h4, 16'h0208);
    q(0, 3'h4, 16'h0208, "enab");
    w(0, 3'h0, 16'hffff);
    q(0, 3'h0, 16'h0, "cond_ro");
    w(0, 3'h1, 16'hffff);
    q(0, 3'h1, 16'h0, "event_ro");
    w(0, 3'h2, 16'h0008);
    q(0, 3'h2, 16'h0008, "rise");
    q(0, 3'h6, 16'h0, "unmapped");
    $display("t_regs done");
  endtask

  task automatic t_power;
    w(1, 3'h4, 16'h0002);
    w(1, 3'h3, 16'h0002);
    st.unleveled = 1'b1;
    wt(10);
    chk("pcond", 16'h0002, pcond);
    q(0, 3'h0, 16'h0008, "qcond_b3");
    chk("summary", 16'h1, {15'h0, ques_summary});
    q(1, 3'h1, 16'h0002, "pev_rise");
    q(1, 3'h1, 16'h0, "pev_clr");
    st.unleveled = 1'b0;
    wt(10);
    q(1, 3'h1, 16'h0002, "pev_fall");
    q(0, 3'h1, 16'h0008, "qev_held");
    chk("summary_clr", 16'h0, {15'h0, ques_summary});
    $display("t_power done");
  endtask

  // three ways out of a trip: clear command, legacy command, front panel
  task automatic t_guard;
    for (int m = 0; m < 3; m++) begin
      st.guard_trip = 1'b1;
      wt(10);
      chk("rf_off", 16'h0, {15'h0, rf});
      chk("pcond_b0", 16'h1, pcond);
      st.guard_trip = 1'b0;
      wt(10);
      chk("rf_held", 16'h0, {15'h0, rf});
      lg = (m == 1);
      if (m == 0) u_ctl.send(1, 0, 3'h5, 16'h0, 1, 0);
      else if (m == 1) u_ctl.send(0, 1, 3'h5, 16'h0, 0, 0);
      else fp = 1'b1;
      wt(10);
      chk("rf_back", 16'h1, {15'h0, rf});
      fp = 1'b0;
      lg = 1'b0;
    end
    $display("t_guard done");
  endtask

  task automatic t_cond;
    st = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    wt(10);
    q(0, 3'h0, 16'h13b0, "qcond");
    st = '0;
    wt(10);
    u_ctl.send(1, 0, 3'h5, 16'h0, 0, 1);
    q(0, 3'h0, 16'h0200, "selftest_kept");
    q(1, 3'h1, 16'h0, "cls_pev");
    $display("t_cond done");
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    fp = 1'b0;
    lg = 1'b0;
    st = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_regs();
    t_power();
    t_guard();
    t_cond();
    report_and_stop();
  end

  // watchdog far past the few hundred cycles the tests need
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule

// ==== src/qsp_pkg.sv ====
// Notes on behaviour
// - questionable condition mirrors live status; remote writes never change it
// - queries return the set bits as a plain binary weight sum
// - rising condition edge sets event bit when rising filter bit enabled
// - falling condition edge sets event bit when falling filter bit enabled
// - event bits stay set after condition returns to earlier state
// - event read returns contents then clears; event writes are ignored
// - status byte bit 3 is OR of enabled questionable event bits
// - enable mask stores written value and reads back exactly
// - questionable bit 3 is OR of enabled output-power event bits
// - power bit 0 while reverse guard tripped; RF output held off
// - guard trip cleared by protection-clear command, front-panel reset or, in legacy mode, any command
// - power bit 1 while leveling loop cannot reach requested power
// - power condition bits 2 to 15 always zero
// - power subgroup has own condition, filters, event and enable registers
// - questionable bit 5 comes from frequency subgroup summary input
// - bit 4 oven cold; bits 7,8,12 subgroup summaries; others zero
// - bit 9 self-test failure, cleared only by power cycle
package qsp_pkg;
  localparam int QSP_W = 16;

  // register selector within a group
  localparam logic [2:0] QSP_REG_COND = 3'h0;
  localparam logic [2:0] QSP_REG_EVENT = 3'h1;
  localparam logic [2:0] QSP_REG_RISE = 3'h2;
  localparam logic [2:0] QSP_REG_FALL = 3'h3;
  localparam logic [2:0] QSP_REG_ENAB = 3'h4;

  // group selector
  localparam logic QSP_GRP_QUES = 1'b0;
  localparam logic QSP_GRP_POW = 1'b1;

  // field positions
  localparam int QSP_Q_POW_BIT = 3;
  localparam int QSP_Q_OVEN_BIT = 4;
  localparam int QSP_Q_FREQ_BIT = 5;
  localparam int QSP_Q_MOD_BIT = 7;
  localparam int QSP_Q_CAL_BIT = 8;
  localparam int QSP_Q_SELF_BIT = 9;
  localparam int QSP_Q_BERT_BIT = 12;
  localparam int QSP_P_GUARD_BIT = 0;
  localparam int QSP_P_LEVEL_BIT = 1;
  localparam int QSP_STB_QUES_BIT = 3;

  // reset values
  localparam logic [15:0] QSP_FILT_RISE_RST = 16'hffff;
  localparam logic [15:0] QSP_FILT_FALL_RST = 16'h0000;
  localparam logic [15:0] QSP_ENAB_RST = 16'h0000;
  localparam logic [15:0] QSP_EVENT_RST = 16'h0000;

  // remote command from the command parser
  typedef struct packed {
    logic valid;      // one-cycle strobe
    logic write;      // 1 setting, 0 query
    logic group;      // QSP_GRP_*
    logic [2:0] sel;  // QSP_REG_*
    logic [15:0] data;
    logic prot_clear; // protection-clear command
    logic cls;        // clear-status command
  } qsp_cmd_t;

  // raw status inputs from hardware and firmware
  typedef struct packed {
    logic guard_trip;  // reverse power detector fired
    logic unleveled;
    logic oven_cold;
    logic self_test_fail;
    logic freq_summary;
    logic mod_summary;
    logic cal_summary;
    logic bert_summary;
  } qsp_stat_t;
endpackage

// ==== src/qsp_status.sv ====
`timescale 1ns/100ps
module qsp_status
  import qsp_pkg::*;
#(
  parameter int W = QSP_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire qsp_cmd_t cmd,
  input wire qsp_stat_t stat_pin,
  input wire logic front_panel_guard_reset,
  input wire logic legacy_mode,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic ques_summary,
  output logic rf_output_enable,
  output logic [15:0] output_power_condition
);
  localparam int NS = 8;

  // three-stage synchronisers for the asynchronous status pins
  logic [NS-1:0] s1, s2, s3, next_s1, next_s2, next_s3;
  logic fp1, fp2, fp3, next_fp1, next_fp2, next_fp3;
  always_comb begin
    next_s1 = stat_pin;
    next_s2 = s1;
    next_s3 = s2;
    next_fp1 = front_panel_guard_reset;
    next_fp2 = fp1;
    next_fp3 = fp2;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      fp1 <= 1'b0;
      fp2 <= 1'b0;
      fp3 <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      fp1 <= next_fp1;
      fp2 <= next_fp2;
      fp3 <= next_fp3;
    end
  end

  // a change counts only once stages two and three agree
  logic [NS-1:0] st, next_st;
  logic fp, next_fp, fp_q, next_fp_q;
  qsp_stat_t sv;
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      next_st[i] = (s2[i] == s3[i]) ? s3[i] : st[i];
    end
    next_fp = (fp2 == fp3) ? fp3 : fp;
    next_fp_q = fp;
    sv = qsp_stat_t'(st);
  end

  // guard trip latch; hardware trip wins over any clear
  logic guard, next_guard, self_fail, next_self_fail;
  logic any_cmd;
  always_comb begin
    any_cmd = cmd.valid && legacy_mode;
    next_guard = guard;
    if ((cmd.valid && cmd.prot_clear) || (fp && !fp_q) || any_cmd)
      next_guard = 1'b0;
    if (sv.guard_trip)
      next_guard = 1'b1;
    // sticky until power cycle; clear-status deliberately ignored
    next_self_fail = self_fail | sv.self_test_fail;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      fp <= 1'b0;
      fp_q <= 1'b0;
      guard <= 1'b0;
      self_fail <= 1'b0;
    end else begin
      st <= next_st;
      fp <= next_fp;
      fp_q <= next_fp_q;
      guard <= next_guard;
      self_fail <= next_self_fail;
    end
  end

  // per-group filter, event and enable state, index 0 ques, 1 power
  logic [W-1:0] cond [2];
  logic [W-1:0] cond_q [2], next_cond_q [2];
  logic [W-1:0] evt [2], next_evt [2];
  logic [W-1:0] rise [2], next_rise [2];
  logic [W-1:0] fall [2], next_fall [2];
  logic [W-1:0] enab [2], next_enab [2];
  logic [1:0] summ;

  // live condition words, no storage so writes cannot touch them
  always_comb begin
    cond[1] = '0;
    cond[1][QSP_P_GUARD_BIT] = guard;
    cond[1][QSP_P_LEVEL_BIT] = sv.unleveled;
    cond[0] = '0;
    cond[0][QSP_Q_POW_BIT] = summ[1];
    cond[0][QSP_Q_OVEN_BIT] = sv.oven_cold;
    cond[0][QSP_Q_FREQ_BIT] = sv.freq_summary;
    cond[0][QSP_Q_MOD_BIT] = sv.mod_summary;
    cond[0][QSP_Q_CAL_BIT] = sv.cal_summary;
    cond[0][QSP_Q_SELF_BIT] = self_fail;
    cond[0][QSP_Q_BERT_BIT] = sv.bert_summary;
  end

  for (genvar g = 0; g < 2; g++) begin : grp
    logic hit, rd_evt, wr;
    logic [W-1:0] caught;
    always_comb begin
      hit = cmd.valid && (cmd.group == 1'(g));
      wr = hit && cmd.write;
      rd_evt = hit && !cmd.write && (cmd.sel == QSP_REG_EVENT);
      caught = (cond[g] & ~cond_q[g] & rise[g])
             | (~cond[g] & cond_q[g] & fall[g]);
      next_cond_q[g] = cond[g];
      // new captures survive a same-cycle destructive read
      next_evt[g] = (rd_evt ? '0 : evt[g])
                  | caught;
      next_rise[g] = (wr && cmd.sel == QSP_REG_RISE) ? cmd.data[W-1:0]
                                                      : rise[g];
      next_fall[g] = (wr && cmd.sel == QSP_REG_FALL) ? cmd.data[W-1:0]
                                                      : fall[g];
      next_enab[g] = (wr && cmd.sel == QSP_REG_ENAB) ? cmd.data[W-1:0]
                                                      : enab[g];
      // clear-status empties events only, filters and masks keep
      if (cmd.valid && cmd.cls)
        next_evt[g] = caught;
      summ[g] = |(evt[g] & enab[g]);
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cond_q[g] <= '0;
        evt[g] <= QSP_EVENT_RST[W-1:0];
        rise[g] <= QSP_FILT_RISE_RST[W-1:0];
        fall[g] <= QSP_FILT_FALL_RST[W-1:0];
        enab[g] <= QSP_ENAB_RST[W-1:0];
      end else begin
        cond_q[g] <= next_cond_q[g];
        evt[g] <= next_evt[g];
        rise[g] <= next_rise[g];
        fall[g] <= next_fall[g];
        enab[g] <= next_enab[g];
      end
    end
  end

  // query answer one cycle after the command; binary equals weight sum
  logic [15:0] next_rd_data;
  logic next_rd_valid;
  logic gi;
  always_comb begin
    gi = cmd.group;
    next_rd_valid = cmd.valid && !cmd.write;
    next_rd_data = rd_data;
    if (next_rd_valid) begin
      unique case (cmd.sel)
        QSP_REG_COND: next_rd_data = 16'(cond[gi]);
        QSP_REG_EVENT: next_rd_data = 16'(evt[gi]);
        QSP_REG_RISE: next_rd_data = 16'(rise[gi]);
        QSP_REG_FALL: next_rd_data = 16'(fall[gi]);
        QSP_REG_ENAB: next_rd_data = 16'(enab[gi]);
        default: next_rd_data = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  assign ques_summary = summ[0];
  assign rf_output_enable = !guard;
  assign output_power_condition = 16'(cond[1]);
endmodule
